/* File: upcr_pkg.sv */
`default_nettype none
package upcr_pkg;
	localparam logic [5:0] FUNC_WR_ADDR = 6'h04;
	localparam logic [5:0] FUNC_SET_ADDR = 6'h05;
	localparam logic [5:0] FUNC_CLR_ADDR = 6'h06;
	localparam logic [5:0] IFC_WR_ADDR = 6'h07;
	localparam logic [5:0] IFC_SET_ADDR = 6'h08;
	localparam logic [5:0] IFC_CLR_ADDR = 6'h09;
	localparam logic [5:0] PD_WR_ADDR = 6'h0a;
	localparam logic [5:0] PD_SET_ADDR = 6'h0b;
	localparam logic [5:0] PD_CLR_ADDR = 6'h0c;
	// writable bit masks
	localparam logic [7:0] FUNC_MASK = 8'h7f;
	localparam logic [7:0] IFC_MASK = 8'h88;
	localparam logic [7:0] PD_MASK = 8'h06;
	localparam logic [7:0] FUNC_RESET = 8'h41;
	localparam logic [7:0] IFC_RESET = 8'h00;
	localparam logic [7:0] PD_RESET = 8'h06;
	localparam int FUNC_XRST_BIT = 5;
	localparam int FUNC_SUSP_BIT = 6;
	localparam int IFC_CLKSUSP_BIT = 3;
	localparam int IFC_PROT_BIT = 7;
	localparam int PD_PLUS_BIT = 1;
	localparam int PD_MINUS_BIT = 2;
	localparam int FUNC_SPEED_LSB = 0;
	localparam int FUNC_TERM_BIT = 2;
	localparam int FUNC_ENC_LSB = 3;
	localparam logic [7:0] XRST_CYCLES = 8'h10;
	localparam logic [7:0] RXCMD_GAP_CYCLES = 8'h02;

	typedef enum logic [2:0] {
		XR_IDLE = 3'b000,
		XR_BUSY = 3'b001,
		XR_GAP = 3'b011,
		XR_RXCMD = 3'b010
	} upcr_xrst_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} upcr_req_s;

	typedef struct packed {
		logic [1:0] speed_select;
		logic termination_select;
		logic [1:0] transmit_encoding_mode;
		logic suspend_n;
		logic clock_suspend_n;
		logic protect_disable;
		logic plus_line_pulldown_en;
		logic minus_line_pulldown_en;
		logic clock_run;
	} upcr_ctl_s;
endpackage : upcr_pkg
`default_nettype wire

/* File: upcr_regbyte.sv */
`timescale 1ns/1ns
`default_nettype none
// one register byte with write, set and clear strobes
module upcr_regbyte #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hff
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// access
	input wire logic wr_i,
	input wire logic set_i,
	input wire logic clr_i,
	input wire logic [7:0] data_i,
	// hardware overrides
	input wire logic [7:0] hw_set_i,
	input wire logic [7:0] hw_clr_i,
	output logic [7:0] q_o
);
	logic [7:0] q_d;
	logic [7:0] q_q;

	always_comb begin
		q_d = q_q;
		if (wr_i) begin
			q_d = data_i;
		end else if (set_i) begin
			q_d = q_q | data_i;
		end else if (clr_i) begin
			q_d = q_q & ~data_i;
		end
		q_d = (q_d & ~hw_clr_i) | hw_set_i;
		q_d = q_d & WR_MASK;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_q <= RESET_VAL;
		end else begin
			q_q <= q_d;
		end
	end

	assign q_o = q_q;
endmodule : upcr_regbyte
`default_nettype wire

/* File: upcr_ulpi_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - function control reads 04-06, write/set/clear 04/05/06
// - interface control reads 07-09, write/set/clear 07/08/09
// - pulldown control reads 0a-0c, write/set/clear 0a/0b/0c
// - set alias ORs byte into register
// - clear alias zeroes bits masked by byte
// - speed select bits 1:0, reset 01
// - transmit encoding bits 4:3, reset 00
// - termination select bit 2 drives terminations
// - reset bit asserts dir, then self-clears
// - after reset, dir again with rx cmd
// - transceiver reset keeps registers intact
// - suspend_n bit 6 zero enters low power
// - low power keeps FS receiver, comparators, pins
// - leaving low power sets suspend_n again
// - clock_suspend_n bit 3, ignored while suspended
// - interface bit 7 disables ULPI protect pulls
// - pulldown bit 1 connects D+ pulldown
// - pulldown bit 2 connects D- pulldown
// - unimplemented bits read as zero
module upcr_ulpi_regs
	import upcr_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register access from the ulpi engine
	input wire upcr_pkg::upcr_req_s req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic invalid_addr_o,
	// transceiver reset handshake
	output logic dir_o,
	output logic rxcmd_req_o,
	output logic xcvr_reset_o,
	// low power exit event from the analog side
	input wire logic lp_exit_i,
	// control outputs
	output upcr_pkg::upcr_ctl_s ctl_o
);
	import upcr_pkg::*;

	typedef struct packed {
		upcr_xrst_e xr;
		logic [7:0] cnt;
		logic [7:0] rdata;
		logic rvalid;
		logic invalid;
	} upcr_state_s;

	upcr_state_s s_q;
	upcr_state_s s_d;
	logic rst_n;
	logic [1:0] rst_sync_q;
	logic [7:0] func_q;
	logic [7:0] ifc_q;
	logic [7:0] pd_q;
	logic [7:0] func_hw_set;
	logic [7:0] func_hw_clr;
	logic wr_func;
	logic set_func;
	logic clr_func;
	logic wr_ifc;
	logic set_ifc;
	logic clr_ifc;
	logic wr_pd;
	logic set_pd;
	logic clr_pd;

	// reset release through two flops
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// address decode
	always_comb begin
		wr_func = req_i.wr && req_i.addr == FUNC_WR_ADDR;
		set_func = req_i.wr && req_i.addr == FUNC_SET_ADDR;
		clr_func = req_i.wr && req_i.addr == FUNC_CLR_ADDR;
		wr_ifc = req_i.wr && req_i.addr == IFC_WR_ADDR;
		set_ifc = req_i.wr && req_i.addr == IFC_SET_ADDR;
		clr_ifc = req_i.wr && req_i.addr == IFC_CLR_ADDR;
		wr_pd = req_i.wr && req_i.addr == PD_WR_ADDR;
		set_pd = req_i.wr && req_i.addr == PD_SET_ADDR;
		clr_pd = req_i.wr && req_i.addr == PD_CLR_ADDR;
	end

	// hardware clears reset bit at completion, restores suspend_n on wake
	always_comb begin
		func_hw_set = '0;
		func_hw_clr = '0;
		if (s_q.xr == XR_BUSY && s_q.cnt == 8'h00) begin
			func_hw_clr[FUNC_XRST_BIT] = 1'b1;
		end
		// wake beats a link clear landing in the same cycle
		if (lp_exit_i) begin
			func_hw_set[FUNC_SUSP_BIT] = 1'b1;
		end
	end

	// registers live outside the transceiver reset domain
	upcr_regbyte #(
		.RESET_VAL(FUNC_RESET),
		.WR_MASK(FUNC_MASK)
	) u_func (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.wr_i(wr_func),
		.set_i(set_func),
		.clr_i(clr_func),
		.data_i(req_i.wdata),
		.hw_set_i(func_hw_set),
		.hw_clr_i(func_hw_clr),
		.q_o(func_q)
	);

	upcr_regbyte #(
		.RESET_VAL(IFC_RESET),
		.WR_MASK(IFC_MASK)
	) u_ifc (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.wr_i(wr_ifc),
		.set_i(set_ifc),
		.clr_i(clr_ifc),
		.data_i(req_i.wdata),
		.hw_set_i(8'h00),
		.hw_clr_i(8'h00),
		.q_o(ifc_q)
	);

	upcr_regbyte #(
		.RESET_VAL(PD_RESET),
		.WR_MASK(PD_MASK)
	) u_pd (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.wr_i(wr_pd),
		.set_i(set_pd),
		.clr_i(clr_pd),
		.data_i(req_i.wdata),
		.hw_set_i(8'h00),
		.hw_clr_i(8'h00),
		.q_o(pd_q)
	);

	// read path and transceiver reset sequencer
	always_comb begin
		s_d = s_q;
		s_d.rvalid = req_i.rd;
		s_d.invalid = 1'b0;
		if (req_i.rd) begin
			unique case (req_i.addr)
				FUNC_WR_ADDR, FUNC_SET_ADDR, FUNC_CLR_ADDR: s_d.rdata = func_q;
				IFC_WR_ADDR, IFC_SET_ADDR, IFC_CLR_ADDR: s_d.rdata = ifc_q;
				PD_WR_ADDR, PD_SET_ADDR, PD_CLR_ADDR: s_d.rdata = pd_q;
				default: begin
					s_d.rdata = 8'h00;
					s_d.invalid = 1'b1;
				end
			endcase
		end else if (req_i.wr) begin
			s_d.invalid = !(req_i.addr >= FUNC_WR_ADDR && req_i.addr <= PD_CLR_ADDR);
		end
		unique case (s_q.xr)
			XR_IDLE: begin
				if (func_q[FUNC_XRST_BIT]) begin
					s_d.xr = XR_BUSY;
					s_d.cnt = XRST_CYCLES - 8'h01;
				end
			end
			XR_BUSY: begin
				if (s_q.cnt == 8'h00) begin
					s_d.xr = XR_GAP;
					s_d.cnt = RXCMD_GAP_CYCLES - 8'h01;
				end else begin
					s_d.cnt = s_q.cnt - 8'h01;
				end
			end
			XR_GAP: begin
				if (s_q.cnt == 8'h00) begin
					s_d.xr = XR_RXCMD;
				end else begin
					s_d.cnt = s_q.cnt - 8'h01;
				end
			end
			XR_RXCMD: begin
				s_d.xr = XR_IDLE;
			end
			default: begin
				s_d.xr = XR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q.xr <= XR_IDLE;
			s_q.cnt <= 8'h00;
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
			s_q.invalid <= 1'b0;
		end else begin
			s_q.xr <= s_d.xr;
			s_q.cnt <= s_d.cnt;
			s_q.rdata <= s_d.rdata;
			s_q.rvalid <= s_d.rvalid;
			s_q.invalid <= s_d.invalid;
		end
	end

	assign rdata_o = s_q.rdata;
	assign rvalid_o = s_q.rvalid;
	assign invalid_addr_o = s_q.invalid;
	assign dir_o = s_q.xr == XR_BUSY || s_q.xr == XR_RXCMD;
	assign rxcmd_req_o = s_q.xr == XR_RXCMD;
	assign xcvr_reset_o = s_q.xr == XR_BUSY;

	// control fan-out to the analog front end
	always_comb begin
		ctl_o.speed_select = func_q[FUNC_SPEED_LSB +: 2];
		ctl_o.termination_select = func_q[FUNC_TERM_BIT];
		ctl_o.transmit_encoding_mode = func_q[FUNC_ENC_LSB +: 2];
		ctl_o.suspend_n = func_q[FUNC_SUSP_BIT];
		ctl_o.clock_suspend_n = ifc_q[IFC_CLKSUSP_BIT];
		// clock suspend only honoured while powered
		ctl_o.clock_run = func_q[FUNC_SUSP_BIT] && ifc_q[IFC_CLKSUSP_BIT];
		ctl_o.protect_disable = ifc_q[IFC_PROT_BIT];
		ctl_o.plus_line_pulldown_en = pd_q[PD_PLUS_BIT];
		ctl_o.minus_line_pulldown_en = pd_q[PD_MINUS_BIT];
	end
endmodule : upcr_ulpi_regs
`default_nettype wire

/* File: upcr_link_model.sv */
`timescale 1ns/1ns
`default_nettype none
// link side: one byte per call, stays off the bus while dir is up, for at most 64 cycles
module upcr_link_model
	import upcr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic dir_i,
	input wire logic rvalid_i,
	input wire logic [7:0] rdata_i,
	output upcr_pkg::upcr_req_s req_o
);
	initial req_o = '0;
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		while (dir_i && n < 64) begin
			@(posedge mclk_i);
			n++;
		end
		@(posedge mclk_i);
		req_o <= '{w, !w, a, d};
		@(posedge mclk_i);
		req_o <= '{1'b0, 1'b0, ~a, ~d};
		#1;
		q = rvalid_i ? rdata_i : 8'hxx;
	endtask : acc
endmodule : upcr_link_model
`default_nettype wire

/* File: upcr_ulpi_regs_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module upcr_ulpi_regs_asserts
	import upcr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire upcr_pkg::upcr_req_s req_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic invalid_addr_o,
	input wire logic dir_o,
	input wire logic rxcmd_req_o,
	input wire logic xcvr_reset_o,
	input wire logic lp_exit_i,
	input wire upcr_pkg::upcr_ctl_s ctl_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd; req_i.rd && !req_i.wr |=> rvalid_o; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_bad; (req_i.rd || req_i.wr) && !(req_i.addr inside {[6'h04:6'h0c]})
		|=> invalid_addr_o; endproperty
	a_bad: assert property (p_bad) else $error("unmapped not flagged");
	property p_rsv; req_i.rd && req_i.addr inside {[6'h0a:6'h0c]}
		|=> rdata_o[0] == 1'b0 && rdata_o[7:3] == 5'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_set; req_i.wr && req_i.addr == 6'h0b && req_i.wdata[1]
		|=> ctl_o.plus_line_pulldown_en; endproperty
	a_set: assert property (p_set) else $error("set lost");
	property p_clr; req_i.wr && req_i.addr == 6'h0c && req_i.wdata[2]
		|=> !ctl_o.minus_line_pulldown_en; endproperty
	a_clr: assert property (p_clr) else $error("clear lost");
	property p_xr; $rose(xcvr_reset_o) |-> dir_o [*8]; endproperty
	a_xr: assert property (p_xr) else $error("dir dropped early");
	property p_xrlen; $rose(xcvr_reset_o) |-> ##15 xcvr_reset_o ##1 !xcvr_reset_o; endproperty
	a_xrlen: assert property (p_xrlen) else $error("reset length wrong");
	property p_rx; $fell(xcvr_reset_o) |-> !dir_o ##1 !dir_o ##1 (dir_o && rxcmd_req_o);
	endproperty
	a_rx: assert property (p_rx) else $error("no rx cmd");
	property p_wake; lp_exit_i |=> ctl_o.suspend_n; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_ck; ctl_o.clock_run == (ctl_o.suspend_n && ctl_o.clock_suspend_n); endproperty
	a_ck: assert property (p_ck) else $error("clock run wrong");
endmodule : upcr_ulpi_regs_asserts
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import upcr_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic lp_exit_i = 1'b0;
	logic [7:0] rdata, q;
	logic rvalid, dir;
	logic inval, xrst, rxcmd;
	upcr_req_s req;
	upcr_ctl_s ctl;
	int errors = 0;
	int n_tests = 0;
	always #5 mclk_i = ~mclk_i;
	upcr_ulpi_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
		.rvalid_o(rvalid), .invalid_addr_o(inval), .dir_o(dir), .rxcmd_req_o(rxcmd),
		.xcvr_reset_o(xrst), .lp_exit_i(lp_exit_i), .ctl_o(ctl));
	upcr_link_model lnk (.mclk_i(mclk_i), .dir_i(dir), .rvalid_i(rvalid), .rdata_i(rdata),
		.req_o(req));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		lnk.acc(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask : rd
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		lnk.acc(1'b1, a, d, q);
		@(posedge mclk_i);
		#1;
	endtask : wr
	task automatic t_reset;
		rd(6'h04, 8'h41);
		rd(6'h07, 8'h00);
		rd(6'h0a, 8'h06);
		chk({ctl.termination_select, ctl.protect_disable, ctl.clock_suspend_n,
			ctl.plus_line_pulldown_en, ctl.minus_line_pulldown_en, 3'h0}, 8'h18);
	endtask : t_reset
	task automatic t_alias;
		logic [5:0] b;
		logic [7:0] d, m, c, s;
		for (int i = 0; i < 3; i++) begin
			b = 6'h04 + 6'(3 * i);
			d = (i == 0) ? 8'hd6 : (i == 1) ? 8'hf8 : 8'hff;
			m = (i == 0) ? 8'h56 : (i == 1) ? 8'h88 : 8'h06;
			c = (i == 0) ? 8'h50 : (i == 1) ? 8'h80 : 8'h00;
			s = (i == 0) ? 8'h55 : (i == 1) ? 8'h88 : 8'h04;
			wr(b, d);
			for (int k = 0; k < 3; k++) begin
				rd(b + 6'(k), m);
			end
			wr(b + 6'h2, (i == 1) ? 8'h08 : 8'h0f);
			rd(b, c);
			wr(b + 6'h1, (i == 1) ? 8'h08 : 8'h05);
			rd(b + 6'h2, s);
		end
		chk({ctl.termination_select, ctl.protect_disable, ctl.clock_suspend_n,
			ctl.plus_line_pulldown_en, ctl.minus_line_pulldown_en, 3'h0}, 8'he8);
	endtask : t_alias
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			wr(6'h04, {3'b010, 2'(3 - i), 1'b0, 2'(i)});
			chk({4'h0, ctl.speed_select, ctl.transmit_encoding_mode},
				{4'h0, 2'(i), 2'(3 - i)});
		end
	endtask : t_modes
	task automatic t_unmapped;
		rd(6'h20, 8'h00);
		chk({7'h0, inval}, 8'h01);
	endtask : t_unmapped
	task automatic t_xrst;
		wr(6'h05, 8'h20);
		chk({5'h0, dir, xrst, rxcmd}, 8'h06);
		repeat (15) @(posedge mclk_i);
		#1;
		chk({5'h0, dir, xrst, rxcmd}, 8'h06);
		@(posedge mclk_i);
		#1;
		chk({5'h0, dir, xrst, rxcmd}, 8'h00);
		@(posedge mclk_i);
		#1;
		chk({5'h0, dir, xrst, rxcmd}, 8'h00);
		@(posedge mclk_i);
		#1;
		chk({5'h0, dir, xrst, rxcmd}, 8'h05);
		@(posedge mclk_i);
		#1;
		chk({5'h0, dir, xrst, rxcmd}, 8'h00);
		rd(6'h04, 8'h43);
	endtask : t_xrst
	task automatic t_lp;
		wr(6'h08, 8'h08);
		chk({6'h0, ctl.suspend_n, ctl.clock_run}, 8'h03);
		wr(6'h06, 8'h40);
		chk({6'h0, ctl.suspend_n, ctl.clock_run}, 8'h00);
		@(posedge mclk_i);
		lp_exit_i <= 1'b1;
		@(posedge mclk_i);
		lp_exit_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk({6'h0, ctl.suspend_n, ctl.clock_run}, 8'h03);
	endtask : t_lp
	task automatic complete_run;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		t_reset;
		t_alias;
		t_modes;
		t_unmapped;
		t_xrst;
		t_lp;
		complete_run;
	end
	initial begin
		#20000;
		errors++;
		complete_run;
	end
endmodule : tb_top
bind upcr_ulpi_regs upcr_ulpi_regs_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .invalid_addr_o(invalid_addr_o),
	.dir_o(dir_o), .rxcmd_req_o(rxcmd_req_o), .xcvr_reset_o(xcvr_reset_o),
	.lp_exit_i(lp_exit_i), .ctl_o(ctl_o));
`default_nettype wire
